// >>> core/level_timeout.sv
`timescale 1ns/1ps
`include "twowire_map.svh"

module level_timeout (
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic [1:0] sel,
    input  wire logic       cond,
    output logic            expired
);
    logic [11:0] count_r;
    logic        fired_r;
    logic [11:0] limit;

    // Select code to cycle count; zero switches the timeout off
    function automatic logic [11:0] limit_of(input logic [1:0] s);
        unique case (s)
            2'h0: limit_of = 12'h000;
            2'h1: limit_of = 12'(`TO_SHORT_CYC);
            2'h2: limit_of = 12'(`TO_MID_CYC);
            2'h3: limit_of = 12'(`TO_LONG_CYC);
        endcase
    endfunction

    assign limit = limit_of(sel);

    // Counts while the level holds; fires once, rearms when it drops
    always_ff @(posedge clock)
    begin
        if (sys_rst || !cond || limit == 12'h000)
        begin
            count_r <= 12'h000;
            fired_r <= 1'b0;
            expired <= 1'b0;
        end
        else
        begin
            expired <= !fired_r && (count_r == limit - 12'h001);
            fired_r <= fired_r || (count_r == limit - 12'h001);
            count_r <= fired_r ? count_r : count_r + 12'h001;
        end
    end

    property p_expire_cause;
        @(posedge clock) disable iff (sys_rst)
        expired |-> $past(cond) && $past(count_r) == $past(limit) - 12'h001;
    endproperty
    a_expire_cause: assert property (p_expire_cause) else $error("timeout fired early");
endmodule

// >>> core/twowire_event_flags_tx_buffer.sv
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "twowire_map.svh"

module twowire_event_flags_tx_buffer (
    input  wire logic                          clock,
    input  wire logic                          sys_rst,
    input  wire twowire_types_pkg::reg_req_t   reg_req,
    output logic [31:0]                        rdata,
    input  wire twowire_types_pkg::bus_event_t bus_ev,
    input  wire logic                          tx_take,
    output logic                               tx_valid,
    output logic [7:0]                         tx_data,
    output logic                               rx_space,
    output logic                               abort,
    output logic                               irq
);
    import twowire_types_pkg::*;

    flag_vec_t   sticky_r;
    flag_vec_t   sticky_nxt;
    flag_vec_t   mask_r;
    flag_vec_t   ev_set;
    flag_vec_t   clr_bits;
    flag_vec_t   flag_view;
    logic [3:0]  ctrl_r;
    logic        tx_full_r;
    logic        rx_full_r;
    logic [7:0]  rx_byte_r;
    logic        stop_arb_r;
    logic        clock_low_timeout_hit;
    logic        bus_idle_timeout_hit;
    logic [31:0] rd_mux;

    // Address decode of the register port
    function automatic logic hit(input reg_req_t q, input logic [11:0] ofs);
        hit = (q.addr == ofs);
    endfunction

    wire wr_tx    = reg_req.wr && hit(reg_req, `TX_BYTE_OFS);
    wire wr_clr   = reg_req.wr && hit(reg_req, `FLAG_CLR_OFS);
    wire wr_mask  = reg_req.wr && hit(reg_req, `FLAG_MASK_OFS);
    wire wr_ctrl  = reg_req.wr && hit(reg_req, `CTRL_OFS);
    wire rd_cons  = reg_req.rd && hit(reg_req, `RX_CONSUME_OFS);
    wire tx_load  = wr_tx && !tx_full_r;
    wire tx_over  = wr_tx && tx_full_r;
    wire tx_drain = tx_take && tx_full_r;
    wire rx_under = rd_cons && !rx_full_r;

    // Timeout watchdogs on clock-low and bus-idle levels
    level_timeout u_clock_low_timeout (
        .clock   (clock),
        .sys_rst (sys_rst),
        .sel     (ctrl_r[`CTRL_CLOCK_LOW_TIMEOUT_LSB +: 2]),
        .cond    (bus_ev.scl_low),
        .expired (clock_low_timeout_hit)
    );

    level_timeout u_bus_idle_timeout (
        .clock   (clock),
        .sys_rst (sys_rst),
        .sel     (ctrl_r[`CTRL_BUS_IDLE_TIMEOUT_LSB +: 2]),
        .cond    (bus_ev.bus_idle),
        .expired (bus_idle_timeout_hit)
    );

    // A stop that lost arbitration must not count as a clean master stop
    wire master_stop_flag_ok = bus_ev.stop_sent && !bus_ev.arb_lost && !stop_arb_r;

    // Event sources of the sticky flags; bits 4 and 5 are levels
    always_comb
    begin
        ev_set              = '0;
        ev_set[`F_START]    = bus_ev.start_sent;
        ev_set[`F_REPEATED_START_FLAG]   = bus_ev.repeated_start_flag_seen;
        ev_set[`F_ADDR]     = bus_ev.addr_match;
        ev_set[`F_TXC]      = bus_ev.shift_empty && !tx_full_r;
        ev_set[`F_ACK]      = bus_ev.ack_rx;
        ev_set[`F_NACK]     = bus_ev.nack_rx;
        ev_set[`F_MASTER_STOP_FLAG]    = master_stop_flag_ok;
        ev_set[`F_ARB]      = bus_ev.arb_lost;
        ev_set[`F_BUS_ERROR_FLAG]   = bus_ev.bus_err;
        ev_set[`F_HOLD]     = bus_ev.hold_begin;
        ev_set[`F_TRANSMIT_OVERFLOW_FLAG]     = tx_over;
        ev_set[`F_RECEIVE_UNDERFLOW_FLAG]     = rx_under;
        ev_set[`F_BUS_IDLE_TIMEOUT]     = bus_idle_timeout_hit;
        ev_set[`F_CLOCK_LOW_TIMEOUT]     = clock_low_timeout_hit;
        ev_set[`F_SLAVE_STOP_FLAG]    = bus_ev.stop_seen;
    end

    // Write-one-to-clear; a same-cycle event wins over the clear
    assign clr_bits   = wr_clr ? reg_req.wdata[16:0] : '0;
    assign sticky_nxt = (sticky_r & ~clr_bits) | ev_set;

    // Level flags are live views of the two buffers
    always_comb
    begin
        flag_view          = sticky_r;
        flag_view[`F_RXV]  = rx_full_r;
        flag_view[`F_TXLVL] = !tx_full_r;
    end

    // Sticky flags, mask and control
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            sticky_r <= `STICKY_RST;
            mask_r   <= `FLAG_MASK_RST;
            ctrl_r   <= `CTRL_RST;
        end
        else
        begin
            sticky_r <= sticky_nxt & ~17'h00030;
            if (wr_mask)
                mask_r <= reg_req.wdata[16:0] & ~17'h00030;
            if (wr_ctrl)
                ctrl_r <= reg_req.wdata[3:0];
        end
    end

    // One-entry transmit buffer; a write into a full buffer is dropped
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            tx_full_r <= 1'b0;
            tx_data   <= `TX_BYTE_RST;
        end
        else
        begin
            if (tx_load)
                tx_data <= reg_req.wdata[7:0];
            if (tx_load)
                tx_full_r <= 1'b1;
            else if (tx_drain)
                tx_full_r <= 1'b0;
        end
    end

    assign tx_valid = tx_full_r;

    // One-entry receive buffer; a push beside a consuming read wins
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            rx_full_r <= 1'b0;
            rx_byte_r <= 8'h00;
            rx_space  <= 1'b1;
        end
        else
        begin
            if (bus_ev.rx_push && !rx_full_r)
                rx_byte_r <= bus_ev.rx_byte;
            if (bus_ev.rx_push)
            begin
                rx_full_r <= 1'b1;
                rx_space  <= 1'b0;
            end
            else if (rd_cons)
            begin
                rx_full_r <= 1'b0;
                rx_space  <= 1'b1;
            end
        end
    end

    // Arbitration lost during our stop; cleared when the stop ends
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            stop_arb_r <= 1'b0;
        else if (bus_ev.stop_sent || !bus_ev.stop_active)
            stop_arb_r <= 1'b0;
        else if (bus_ev.arb_lost)
            stop_arb_r <= 1'b1;
    end

    // Read data mux; write-only and unmapped words read zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit(reg_req, `RX_CONSUME_OFS) || hit(reg_req, `RX_PEEK_OFS))
            rd_mux[7:0] = rx_byte_r;
        else if (hit(reg_req, `FLAGS_OFS))
            rd_mux[16:0] = flag_view;
        else if (hit(reg_req, `FLAG_MASK_OFS))
            rd_mux[16:0] = mask_r;
        else if (hit(reg_req, `CTRL_OFS))
            rd_mux[3:0] = ctrl_r;
    end

    // Read answer stands one cycle only; abort and interrupt from flops
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            rdata <= 32'h0000_0000;
            abort <= 1'b0;
            irq   <= 1'b0;
        end
        else
        begin
            rdata <= reg_req.rd ? rd_mux : 32'h0000_0000;
            abort <= bus_ev.bus_err;
            irq   <= |(flag_view & mask_r);
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    wire no_clr_of_all = !wr_clr;

    sequence s_err_seen;
        bus_ev.bus_err && no_clr_of_all;
    endsequence
    sequence s_abort_once;
        abort ##1 !abort || $past(bus_ev.bus_err, 1);
    endsequence
    sequence s_stop_lost;
        bus_ev.stop_active && bus_ev.arb_lost ##1 (bus_ev.stop_active && !bus_ev.arb_lost)[*1];
    endsequence

    property p_tx_load;
        tx_load |=> tx_valid && tx_data == $past(reg_req.wdata[7:0]) && !flag_view[`F_TXLVL];
    endproperty
    a_tx_load: assert property (p_tx_load) else $error("byte not loaded");

    property p_slave_stop_flag;
        bus_ev.stop_seen |=> sticky_r[`F_SLAVE_STOP_FLAG];
    endproperty
    a_slave_stop_flag: assert property (p_slave_stop_flag) else $error("slave stop flag missed");

    property p_clock_low_timeout;
        clock_low_timeout_hit |=> sticky_r[`F_CLOCK_LOW_TIMEOUT] ##1 (sticky_r[`F_CLOCK_LOW_TIMEOUT] || $past(wr_clr));
    endproperty
    a_clock_low_timeout: assert property (p_clock_low_timeout) else $error("clock low flag missed");

    property p_bus_idle_timeout;
        bus_idle_timeout_hit |=> sticky_r[`F_BUS_IDLE_TIMEOUT];
    endproperty
    a_bus_idle_timeout: assert property (p_bus_idle_timeout) else $error("bus idle flag missed");

    property p_receive_underflow_flag;
        rx_under |=> sticky_r[`F_RECEIVE_UNDERFLOW_FLAG] && !rx_full_r || $past(bus_ev.rx_push);
    endproperty
    a_receive_underflow_flag: assert property (p_receive_underflow_flag) else $error("underflow flag missed");

    property p_transmit_overflow_flag;
        tx_over && !tx_take |=> sticky_r[`F_TRANSMIT_OVERFLOW_FLAG] && $stable(tx_data) && tx_valid;
    endproperty
    a_transmit_overflow_flag: assert property (p_transmit_overflow_flag) else $error("overflow mishandled");

    property p_hold;
        bus_ev.hold_begin |=> sticky_r[`F_HOLD];
    endproperty
    a_hold: assert property (p_hold) else $error("bus held flag missed");

    property p_bus_error_flag;
        s_err_seen |=> sticky_r[`F_BUS_ERROR_FLAG] && abort;
    endproperty
    a_bus_error_flag: assert property (p_bus_error_flag) else $error("bus error not handled");

    property p_abort_cause;
        abort |-> $past(bus_ev.bus_err);
    endproperty
    a_abort_cause: assert property (p_abort_cause) else $error("stray abort");

    property p_arb;
        bus_ev.arb_lost |=> sticky_r[`F_ARB];
    endproperty
    a_arb: assert property (p_arb) else $error("arbitration flag missed");

    property p_master_stop_flag_lost;
        s_stop_lost ##0 (bus_ev.stop_sent && !sticky_r[`F_MASTER_STOP_FLAG]) |=> !sticky_r[`F_MASTER_STOP_FLAG];
    endproperty
    a_master_stop_flag_lost: assert property (p_master_stop_flag_lost) else $error("master stop after lost arb");

    property p_master_stop_flag_ok;
        bus_ev.stop_sent && !bus_ev.arb_lost && !stop_arb_r |=> sticky_r[`F_MASTER_STOP_FLAG];
    endproperty
    a_master_stop_flag_ok: assert property (p_master_stop_flag_ok) else $error("master stop flag missed");

    property p_acks;
        (bus_ev.ack_rx || bus_ev.nack_rx) |=>
            (sticky_r[`F_ACK] || !$past(bus_ev.ack_rx)) &&
            (sticky_r[`F_NACK] || !$past(bus_ev.nack_rx));
    endproperty
    a_acks: assert property (p_acks) else $error("ack flag missed");

    property p_rxv;
        rd_cons && rx_full_r && !bus_ev.rx_push |=> !flag_view[`F_RXV] && rx_space;
    endproperty
    a_rxv: assert property (p_rxv) else $error("receive valid not cleared");

    property p_txlvl;
        tx_drain && !wr_tx |=> flag_view[`F_TXLVL] && !tx_valid;
    endproperty
    a_txlvl: assert property (p_txlvl) else $error("transmit level not set");

    property p_txc;
        bus_ev.shift_empty && tx_full_r && !sticky_r[`F_TXC] |=> !sticky_r[`F_TXC];
    endproperty
    a_txc: assert property (p_txc) else $error("complete flag with byte queued");

    // Each start-side event checked on its own, so single pulses exercise them
    property p_addr;
        bus_ev.addr_match |=> sticky_r[`F_ADDR];
    endproperty
    a_addr: assert property (p_addr) else $error("address flag missed");

    property p_repeated_start_flag;
        bus_ev.repeated_start_flag_seen |=> sticky_r[`F_REPEATED_START_FLAG];
    endproperty
    a_repeated_start_flag: assert property (p_repeated_start_flag) else $error("repeated start flag missed");

    property p_start;
        bus_ev.start_sent |=> sticky_r[`F_START];
    endproperty
    a_start: assert property (p_start) else $error("start flag missed");

    // No sticky bit may fall unless a clear write came in the cycle before
    property p_sticky_all;
        !wr_clr |=> (($past(sticky_r) & ~sticky_r) == 17'h00000);
    endproperty
    a_sticky_all: assert property (p_sticky_all) else $error("sticky bit lost");

    // Interrupt level tracks unmasked flags one register stage later
    wire irq_want = |(flag_view & mask_r);

    property p_irq_set;
        irq_want |=> irq;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("interrupt missed");

    property p_irq_cause;
        irq |-> $past(irq_want);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("stray interrupt");

    property p_sticky;
        sticky_r[`F_START] && !wr_clr |=> sticky_r[`F_START] [*1] ##0 $stable(sticky_r[`F_START]);
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

    property p_rd_answer;
        reg_req.rd ##1 !reg_req.rd |=> rdata == 32'h0000_0000;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read data held too long");
endmodule

// >>> core/twowire_map.svh
// Notes on behaviour
// - Writing the transmit byte register loads its low eight bits; write-only, resets zero.
// - Slave-stop flag sets on any STOP seen on the bus, involved or not.
// - Clock-low timeout flag sets each time the clock stays low past the timeout.
// - Bus-idle timeout flag sets each time the selected idle timeout expires.
// - Receive-underflow flag sets when the consuming read finds the receive buffer empty.
// - Transmit-overflow flag sets when a byte is written into a full transmit buffer.
// - Bus-held flag sets when the controller starts holding the bus.
// - Bus error sets its flag, aborts the transfer and recovers without software.
// - Arbitration-lost flag sets whenever arbitration to another master is lost.
// - Master-stop flag sets after a clean STOP; stays clear if arbitration lost meanwhile.
// - Not-acknowledge flag sets whenever a NACK is received.
// - Acknowledge flag sets whenever an ACK is received.
// - Receive-valid flag follows receive buffer holding data; cleared by the consuming read.
// - Transmit-level flag high while the buffer is empty; one after reset.
// - Transfer-complete flag sets when shift register empties with no byte buffered.
// - Address flag sets when own or general call address is accepted.
// - Repeated-start flag sets whenever a repeated START is detected.
`ifndef TWOWIRE_MAP_SVH
`define TWOWIRE_MAP_SVH

// Register byte offsets
`define RX_CONSUME_OFS 12'h01C
`define RX_PEEK_OFS    12'h020
`define TX_BYTE_OFS    12'h024
`define FLAGS_OFS      12'h028
`define FLAG_CLR_OFS   12'h030
`define FLAG_MASK_OFS  12'h034
`define CTRL_OFS       12'h038

// Flag bit positions
`define F_START   0
`define F_REPEATED_START_FLAG  1
`define F_ADDR    2
`define F_TXC     3
`define F_TXLVL   4
`define F_RXV     5
`define F_ACK     6
`define F_NACK    7
`define F_MASTER_STOP_FLAG   8
`define F_ARB     9
`define F_BUS_ERROR_FLAG  10
`define F_HOLD    11
`define F_TRANSMIT_OVERFLOW_FLAG    12
`define F_RECEIVE_UNDERFLOW_FLAG    13
`define F_BUS_IDLE_TIMEOUT    14
`define F_CLOCK_LOW_TIMEOUT    15
`define F_SLAVE_STOP_FLAG   16

// Reset values
`define TX_BYTE_RST   8'h00
`define STICKY_RST    17'h00000
`define FLAG_MASK_RST 17'h00000
`define CTRL_RST      4'h0

// Control fields: two-bit timeout selects
`define CTRL_CLOCK_LOW_TIMEOUT_LSB 0
`define CTRL_BUS_IDLE_TIMEOUT_LSB 2

// Timeout choices, least times rounded up to whole cycles
`define CLK_PERIOD_PS 5000
`define TO_SHORT_NS   1000
`define TO_MID_NS     5000
`define TO_LONG_NS    20000
`define TO_SHORT_CYC  ((`TO_SHORT_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define TO_MID_CYC    ((`TO_MID_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define TO_LONG_CYC   ((`TO_LONG_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// >>> core/twowire_types_pkg.sv
package twowire_types_pkg;

    // Register port request, one cycle per access
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    // Event pulses and levels from the protocol engine
    typedef struct packed {
        logic       start_sent;
        logic       repeated_start_flag_seen;
        logic       addr_match;
        logic       shift_empty;
        logic       ack_rx;
        logic       nack_rx;
        logic       stop_active;
        logic       stop_sent;
        logic       arb_lost;
        logic       bus_err;
        logic       hold_begin;
        logic       stop_seen;
        logic       scl_low;
        logic       bus_idle;
        logic       rx_push;
        logic [7:0] rx_byte;
    } bus_event_t;

    typedef logic [16:0] flag_vec_t;

endpackage

// >>> tb/bus_engine_model.sv
`timescale 1ns/1ps

module bus_engine_model (
    input  wire logic                    clock,
    output twowire_types_pkg::bus_event_t bus_ev,
    output logic                         tx_take
);
    import twowire_types_pkg::*;

    bus_event_t pulse_r;
    bus_event_t level_r;

    // Pulses last one cycle; bus levels persist until the bus changes them
    assign bus_ev = pulse_r | level_r;

    // Quiet engine at time zero
    initial
    begin
        pulse_r = '0;
        level_r = '0;
        tx_take = 1'b0;
    end

    // One-cycle event, launched just after an edge
    task fire(input bus_event_t e);
        @(posedge clock);
        pulse_r <= e;
        @(posedge clock);
        pulse_r <= '0;
    endtask

    // Engine grabs the buffered byte for shifting
    task take();
        @(posedge clock);
        tx_take <= 1'b1;
        @(posedge clock);
        tx_take <= 1'b0;
    endtask

    // Our STOP in progress, held across the pulses that happen during it
    task set_stop(input logic a);
        @(posedge clock);
        level_r.stop_active <= a;
    endtask

    // Clock-low and idle levels, held as long as the bus stays there
    task set_levels(input logic scl, input logic idle);
        @(posedge clock);
        level_r.scl_low  <= scl;
        level_r.bus_idle <= idle;
    endtask
endmodule

// >>> tb/twowire_event_flags_tx_buffer_tb_top.sv
`timescale 1ns/1ps
`include "twowire_map.svh"

module twowire_event_flags_tx_buffer_tb_top;
    import twowire_types_pkg::*;

    logic        clock;
    logic        sys_rst;
    reg_req_t    req;
    logic [31:0] rdata;
    bus_event_t  bus_ev;
    bus_event_t  e;
    logic        tx_take;
    logic        tx_valid;
    logic [7:0]  tx_data;
    logic        rx_space;
    logic        abort;
    logic        irq;
    logic [31:0] val;
    int          errors;
    int          num_checks;
    int          ev_bit [11] = '{0, 1, 2, 3, 6, 7, 8, 9, 10, 11, 16};

    // Free-running 200 MHz clock
    initial clock = 1'b0;
    always #2.5 clock = ~clock;

    twowire_event_flags_tx_buffer twowire_event_flags_tx_buffer_i (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .reg_req  (req),
        .rdata    (rdata),
        .bus_ev   (bus_ev),
        .tx_take  (tx_take),
        .tx_valid (tx_valid),
        .tx_data  (tx_data),
        .rx_space (rx_space),
        .abort    (abort),
        .irq      (irq)
    );

    bus_engine_model bus_engine_model_i (
        .clock   (clock),
        .bus_ev  (bus_ev),
        .tx_take (tx_take)
    );

    // Register port: one-cycle strobes, read data in the following cycle only
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        req.wr <= 1'b0;
    endtask

    task rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clock);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask

    task check_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task check_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task flags_is(input logic [31:0] exp);
        rd(`FLAGS_OFS, val);
        check_word(val, exp);
    endtask

    // One event pulse per engine-driven flag position (0-3, 6-11, 16); other positions give none
    function automatic bus_event_t mk_ev(input int b);
        bus_event_t x;
        x = '0;
        case (b)
            0: x.start_sent = 1'b1;
            1: x.repeated_start_flag_seen = 1'b1;
            2: x.addr_match = 1'b1;
            3: x.shift_empty = 1'b1;
            6: x.ack_rx = 1'b1;
            7: x.nack_rx = 1'b1;
            8: x.stop_sent = 1'b1;
            9: x.arb_lost = 1'b1;
            10: x.bus_err = 1'b1;
            11: x.hold_begin = 1'b1;
            16: x.stop_seen = 1'b1;
            default: x = '0;
        endcase
        return x;
    endfunction

    task finish_test();
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Whole run is under a thousand cycles; 20000 leaves wide margin
    initial
    begin
        #100000;
        errors++;
        finish_test();
    end

    initial
    begin
        sys_rst = 1'b1;
        req = '0;
        errors = 0;
        num_checks = 0;
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        flags_is(32'h10);
        check_bit(tx_valid, 1'b0);
        rd(`TX_BYTE_OFS, val);
        check_word(val, 32'h0);
        rd(12'h0FC, val);
        check_word(val, 32'h0);
        $display("test reset done");
        // Only the low byte is kept; a write into a full buffer is dropped
        wr(`TX_BYTE_OFS, 32'h1A5);
        #1 check_bit(tx_valid, 1'b1);
        check_word({24'h0, tx_data}, 32'hA5);
        wr(`TX_BYTE_OFS, 32'h77);
        flags_is(32'h1000);
        check_word({24'h0, tx_data}, 32'hA5);
        bus_engine_model_i.take();
        #1 check_bit(tx_valid, 1'b0);
        flags_is(32'h1010);
        $display("test tx done");
        // Each event sets its own flag, which a second read still shows
        foreach (ev_bit[k])
        begin
            wr(`FLAG_CLR_OFS, 32'h1FFFF);
            bus_engine_model_i.fire(mk_ev(ev_bit[k]));
            flags_is(32'h10 | (32'h1 << ev_bit[k]));
            flags_is(32'h10 | (32'h1 << ev_bit[k]));
        end
        wr(`FLAG_CLR_OFS, 32'h1FFFF);
        flags_is(32'h10);
        bus_engine_model_i.fire(mk_ev(10));
        #1 check_bit(abort, 1'b1);
        @(posedge clock);
        #1 check_bit(abort, 1'b0);
        // Stop with arbitration lost in the same cycle must not count as clean
        e = mk_ev(8);
        e.arb_lost = 1'b1;
        wr(`FLAG_CLR_OFS, 32'h1FFFF);
        bus_engine_model_i.fire(e);
        flags_is(32'h210);
        // Arbitration lost earlier in the same STOP also blocks the flag
        wr(`FLAG_CLR_OFS, 32'h1FFFF);
        bus_engine_model_i.set_stop(1'b1);
        bus_engine_model_i.fire(mk_ev(9));
        bus_engine_model_i.fire(mk_ev(8));
        bus_engine_model_i.set_stop(1'b0);
        flags_is(32'h210);
        // Shift register empty while a byte still waits is not completion
        wr(`FLAG_CLR_OFS, 32'h1FFFF);
        wr(`TX_BYTE_OFS, 32'h5A);
        bus_engine_model_i.fire(mk_ev(3));
        flags_is(32'h0);
        bus_engine_model_i.take();
        $display("test events done");
        // Receive byte: peek keeps it, consuming read empties, empty read underflows
        e = '0;
        e.rx_push = 1'b1;
        e.rx_byte = 8'h3C;
        bus_engine_model_i.fire(e);
        #1 check_bit(rx_space, 1'b0);
        flags_is(32'h30);
        rd(`RX_PEEK_OFS, val);
        check_word(val, 32'h3C);
        flags_is(32'h30);
        rd(`RX_CONSUME_OFS, val);
        check_word(val, 32'h3C);
        flags_is(32'h10);
        rd(`RX_CONSUME_OFS, val);
        flags_is(32'h2010);
        $display("test rx done");
        // Interrupt follows masked flags only
        wr(`FLAG_CLR_OFS, 32'h1FFFF);
        wr(`FLAG_MASK_OFS, 32'h80);
        bus_engine_model_i.fire(mk_ev(7));
        repeat (2) @(posedge clock);
        #1 check_bit(irq, 1'b1);
        wr(`FLAG_CLR_OFS, 32'h80);
        repeat (2) @(posedge clock);
        #1 check_bit(irq, 1'b0);
        wr(`FLAG_MASK_OFS, 32'h0);
        bus_engine_model_i.fire(mk_ev(7));
        repeat (2) @(posedge clock);
        #1 check_bit(irq, 1'b0);
        wr(`FLAG_CLR_OFS, 32'h1FFFF);
        $display("test irq done");
        // Shortest timeout select: 200 cycles of clock-low, then bus-idle
        for (int k = 0; k < 2; k++)
        begin
            wr(`CTRL_OFS, (k == 0) ? 32'h1 : 32'h4);
            bus_engine_model_i.set_levels(k == 0, k == 1);
            repeat (185) @(posedge clock);
            flags_is(32'h10);
            repeat (20) @(posedge clock);
            flags_is(32'h10 | (32'h1 << (15 - k)));
            bus_engine_model_i.set_levels(1'b0, 1'b0);
            wr(`CTRL_OFS, 32'h0);
            wr(`FLAG_CLR_OFS, 32'h1FFFF);
        end
        $display("test timeouts done");
        finish_test();
    end
endmodule
